//--- inv_link_error_reporter.sv
// transaction outcome classifier for the inverter serial link
// Summary of operation
// - any fault sets flag and loads code
// - no reply at all gives code 1
// - reply stopping midway gives code 2
// - reply from wrong station gives code 3
// - reply checksum mismatch gives code 4
// - bad parameter number: code 5, operand fault
// - port claimed elsewhere: refuse, code 6
// - station out of range: code 7, operand
// - command send too slow gives code 8
// - malformed reply content gives code 9
// - inverter value 0 gives code 256
// - inverter value 1 gives code 257
// - inverter value 2 gives code 258
// - inverter value 3 gives code 259
// - inverter value 4 gives code 260
// - inverter value 5 gives code 261
`timescale 1ns/1ns
module inv_link_error_reporter #(
    parameter int unsigned SEND_CYC = inv_err_pkg::SEND_LIMIT_CYC,
    parameter int unsigned REPLY_CYC = inv_err_pkg::REPLY_LIMIT_CYC,
    parameter int unsigned GAP_CYC = inv_err_pkg::GAP_LIMIT_CYC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // transaction request
    input wire logic start_i,
    input wire logic [7:0] station_i,
    input wire logic param_ok_i,
    input wire logic port_claimed_i,
    // command transmitter
    input wire logic tx_done_i,
    // reply byte stream
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_data_i,
    input wire logic rx_last_i,
    output logic rx_ready_o,
    // outcome
    output logic busy_o,
    output logic done_o,
    output logic err_flag_o,
    output logic [15:0] err_code_o,
    output logic [15:0] instruction_fault_register_o
);
    initial begin
        if (SEND_CYC < 1 || REPLY_CYC < 1 || GAP_CYC < 1) begin
            $error("inv_link_error_reporter: limits must be at least one cycle");
        end
    end

    // ****************************************
    // buffer and timer
    // ****************************************
    logic buf_valid, buf_ready, buf_last;
    logic [7:0] buf_data;
    logic tmr_load, tmr_stop, tmr_exp;
    logic [31:0] tmr_limit;

    inv_rx_buffer #(.WIDTH(9), .DEPTH(2)) u_buf (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .in_valid_i(rx_valid_i),
        .in_data_i({rx_last_i, rx_data_i}),
        .in_ready_o(rx_ready_o),
        .out_valid_o(buf_valid),
        .out_data_o({buf_last, buf_data}),
        .out_ready_i(buf_ready)
    );

    inv_link_timer u_tmr (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .load_i(tmr_load),
        .stop_i(tmr_stop),
        .limit_i(tmr_limit),
        .expire_o(tmr_exp)
    );

    // ****************************************
    // transaction state
    // ****************************************
    inv_err_pkg::txn_state_t state_ff, nxt_state;
    logic [7:0] station_ff, nxt_station;
    logic [7:0] rx_sta_ff, nxt_rx_sta;
    logic [7:0] kind_ff, nxt_kind;
    logic [7:0] nakv_ff, nxt_nakv;
    logic [7:0] sum_ff, nxt_sum;
    logic [1:0] idx_ff, nxt_idx;
    logic busy_ff, nxt_busy;
    logic done_ff, nxt_done;
    logic flag_ff, nxt_flag;
    logic [15:0] code_ff, nxt_code;
    logic [15:0] instr_ff, nxt_instr;
    logic fin;
    logic [15:0] fin_code;
    logic [15:0] fin_instr;

    assign busy_o = busy_ff;
    assign done_o = done_ff;
    assign err_flag_o = flag_ff;
    assign err_code_o = code_ff;
    assign instruction_fault_register_o = instr_ff;
    // the stream is drained only while a reply is expected; otherwise it backs up
    assign buf_ready = (state_ff == inv_err_pkg::ST_WAIT) || (state_ff == inv_err_pkg::ST_RECV);

    always_comb begin
        nxt_state = state_ff;
        nxt_station = station_ff;
        nxt_rx_sta = rx_sta_ff;
        nxt_kind = kind_ff;
        nxt_nakv = nakv_ff;
        nxt_sum = sum_ff;
        nxt_idx = idx_ff;
        fin = 1'b0;
        fin_code = inv_err_pkg::CODE_OK;
        fin_instr = instr_ff;
        tmr_load = 1'b0;
        tmr_stop = 1'b0;
        tmr_limit = 32'h0000_0000;
        case (state_ff)
            inv_err_pkg::ST_IDLE: begin
                if (start_i) begin
                    // port conflict is checked first: nothing goes on the line
                    if (port_claimed_i) begin
                        fin = 1'b1;
                        fin_code = inv_err_pkg::CODE_PORT;
                        fin_instr = inv_err_pkg::INSTR_PORT;
                    end else if (station_i > inv_err_pkg::STATION_MAX) begin
                        fin = 1'b1;
                        fin_code = inv_err_pkg::CODE_RANGE;
                        fin_instr = inv_err_pkg::INSTR_OPERAND;
                    end else if (!param_ok_i) begin
                        fin = 1'b1;
                        fin_code = inv_err_pkg::CODE_PARAM;
                        fin_instr = inv_err_pkg::INSTR_OPERAND;
                    end else begin
                        nxt_state = inv_err_pkg::ST_SEND;
                        nxt_station = station_i;
                        nxt_idx = inv_err_pkg::IDX_STATION;
                        nxt_sum = 8'h00;
                        tmr_load = 1'b1;
                        tmr_limit = SEND_CYC;
                    end
                end
            end
            inv_err_pkg::ST_SEND: begin
                if (tx_done_i) begin
                    nxt_state = inv_err_pkg::ST_WAIT;
                    tmr_load = 1'b1;
                    tmr_limit = REPLY_CYC;
                end else if (tmr_exp) begin
                    fin = 1'b1;
                    fin_code = inv_err_pkg::CODE_SEND_TMO;
                end
            end
            default: begin
                if (buf_valid) begin
                    // a byte beats an expiry in the same cycle
                    nxt_state = inv_err_pkg::ST_RECV;
                    tmr_load = 1'b1;
                    tmr_limit = GAP_CYC;
                    nxt_sum = sum_ff + buf_data;
                    if (idx_ff != inv_err_pkg::IDX_FULL) begin
                        nxt_idx = idx_ff + 2'h1;
                    end
                    case (idx_ff)
                        inv_err_pkg::IDX_STATION: nxt_rx_sta = buf_data;
                        inv_err_pkg::IDX_KIND: nxt_kind = buf_data;
                        inv_err_pkg::IDX_NAKVAL: nxt_nakv = buf_data;
                        default: nxt_idx = inv_err_pkg::IDX_FULL;
                    endcase
                    if (buf_last) begin
                        fin = 1'b1;
                        // the last byte is the checksum and is not in the sum
                        if (idx_ff < inv_err_pkg::IDX_NAKVAL) begin
                            fin_code = inv_err_pkg::CODE_BAD_DATA;
                        end else if (rx_sta_ff != station_ff) begin
                            fin_code = inv_err_pkg::CODE_STATION;
                        end else if (buf_data != sum_ff) begin
                            fin_code = inv_err_pkg::CODE_SUM;
                        end else if (kind_ff == inv_err_pkg::BYTE_ACK) begin
                            fin_code = inv_err_pkg::CODE_OK;
                        end else if (kind_ff == inv_err_pkg::BYTE_NAK
                                     && idx_ff == inv_err_pkg::IDX_FULL
                                     && nakv_ff <= inv_err_pkg::NAK_VAL_MAX) begin
                            fin_code = inv_err_pkg::CODE_NAK_BASE + {8'h00, nakv_ff};
                        end else begin
                            fin_code = inv_err_pkg::CODE_BAD_DATA;
                        end
                    end
                end else if (tmr_exp) begin
                    fin = 1'b1;
                    if (state_ff == inv_err_pkg::ST_WAIT) begin
                        fin_code = inv_err_pkg::CODE_NO_REPLY;
                    end else begin
                        fin_code = inv_err_pkg::CODE_ABORTED;
                    end
                end
            end
        endcase
        if (fin) begin
            nxt_state = inv_err_pkg::ST_IDLE;
            tmr_stop = 1'b1;
            tmr_load = 1'b0;
        end
        nxt_done = fin;
        // flag and code move together on every outcome
        nxt_flag = fin ? (fin_code != inv_err_pkg::CODE_OK) : flag_ff;
        nxt_code = fin ? fin_code : code_ff;
        nxt_instr = fin ? fin_instr : instr_ff;
        nxt_busy = (nxt_state != inv_err_pkg::ST_IDLE);
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_ff <= inv_err_pkg::ST_IDLE;
            station_ff <= 8'h00;
            rx_sta_ff <= 8'h00;
            kind_ff <= 8'h00;
            nakv_ff <= 8'h00;
            sum_ff <= 8'h00;
            idx_ff <= 2'h0;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            flag_ff <= 1'b0;
            code_ff <= 16'h0000;
            instr_ff <= 16'h0000;
        end else begin
            state_ff <= nxt_state;
            station_ff <= nxt_station;
            rx_sta_ff <= nxt_rx_sta;
            kind_ff <= nxt_kind;
            nakv_ff <= nxt_nakv;
            sum_ff <= nxt_sum;
            idx_ff <= nxt_idx;
            busy_ff <= nxt_busy;
            done_ff <= nxt_done;
            flag_ff <= nxt_flag;
            code_ff <= nxt_code;
            instr_ff <= nxt_instr;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    logic idle_start;
    logic last_take;
    assign idle_start = start_i && state_ff == inv_err_pkg::ST_IDLE;
    assign last_take = buf_valid && buf_last && buf_ready;

    // age of the send phase: a counter keeps the long limit out of a repetition
    logic [31:0] send_age_ff, nxt_send_age;
    always_comb begin
        nxt_send_age = 32'h0000_0000;
        if (state_ff == inv_err_pkg::ST_SEND && nxt_state == inv_err_pkg::ST_SEND) begin
            nxt_send_age = send_age_ff + 32'h0000_0001;
        end
    end
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            send_age_ff <= 32'h0000_0000;
        end else begin
            send_age_ff <= nxt_send_age;
        end
    end

    flag_matches_code_a: assert property (done_o |-> err_flag_o == (err_code_o != 16'h0000))
        else $error("error flag disagrees with stored code");
    port_refused_a: assert property (idle_start && port_claimed_i |=>
        done_o && err_code_o == 16'h0006 && instruction_fault_register_o == 16'h1a6a && !busy_o)
        else $error("port conflict not reported");
    station_range_a: assert property (idle_start && !port_claimed_i && station_i > 8'h1f |=>
        err_code_o == 16'h0007 && instruction_fault_register_o == 16'h1a32)
        else $error("station range fault not reported");
    param_bad_a: assert property (idle_start && !port_claimed_i && station_i <= 8'h1f
        && !param_ok_i |=> err_code_o == 16'h0005 && instruction_fault_register_o == 16'h1a32)
        else $error("parameter fault not reported");
    send_timeout_a: assert property (state_ff == inv_err_pkg::ST_SEND && !tx_done_i && tmr_exp
        |=> done_o && err_code_o == 16'h0008)
        else $error("send timeout not reported");
    no_reply_a: assert property (state_ff == inv_err_pkg::ST_WAIT && !buf_valid && tmr_exp
        |=> err_code_o == 16'h0001 && err_flag_o)
        else $error("missing reply not reported");
    reply_aborted_a: assert property (state_ff == inv_err_pkg::ST_RECV && !buf_valid && tmr_exp
        |=> err_code_o == 16'h0002)
        else $error("aborted reply not reported");
    wrong_station_a: assert property (last_take && idx_ff >= 2'h2 && rx_sta_ff != station_ff
        |=> err_code_o == 16'h0003)
        else $error("station mismatch not reported");
    bad_checksum_a: assert property (last_take && idx_ff >= 2'h2 && rx_sta_ff == station_ff
        && buf_data != sum_ff |=> err_code_o == 16'h0004)
        else $error("checksum mismatch not reported");
    nak_mapped_a: assert property (last_take && idx_ff == 2'h3 && rx_sta_ff == station_ff
        && buf_data == sum_ff && kind_ff == 8'h15 && nakv_ff <= 8'h05
        |=> err_code_o == 16'h0100 + {8'h00, $past(nakv_ff)})
        else $error("inverter error value not mapped");
    send_bounded_a: assert property (state_ff == inv_err_pkg::ST_SEND |->
        send_age_ff <= SEND_CYC)
        else $error("send phase outlived its limit");

    clean_end_c: cover property (done_o && !err_flag_o);
    nak_end_c: cover property (done_o && err_code_o >= 16'h0100);
    stall_c: cover property (!rx_ready_o && rx_valid_i);
    no_reply_c: cover property (done_o && err_code_o == 16'h0001);
endmodule

//--- inv_err_pkg.sv
// shared constants and types for the inverter link error reporter
package inv_err_pkg;

    // ****************************************
    // timing
    // ****************************************
    localparam int unsigned CLK_MHZ = 100;
    // limits in microseconds, counts derived at the 100 MHz clock
    localparam int unsigned SEND_LIMIT_US = 1000;
    localparam int unsigned REPLY_LIMIT_US = 10000;
    localparam int unsigned GAP_LIMIT_US = 1000;
    localparam int unsigned SEND_LIMIT_CYC = SEND_LIMIT_US * CLK_MHZ;
    localparam int unsigned REPLY_LIMIT_CYC = REPLY_LIMIT_US * CLK_MHZ;
    localparam int unsigned GAP_LIMIT_CYC = GAP_LIMIT_US * CLK_MHZ;

    // ****************************************
    // reply frame layout
    // ****************************************
    localparam logic [7:0] BYTE_ACK = 8'h06;
    localparam logic [7:0] BYTE_NAK = 8'h15;
    localparam logic [7:0] STATION_MAX = 8'h1f;
    localparam logic [7:0] NAK_VAL_MAX = 8'h05;
    localparam logic [1:0] IDX_STATION = 2'h0;
    localparam logic [1:0] IDX_KIND = 2'h1;
    localparam logic [1:0] IDX_NAKVAL = 2'h2;
    localparam logic [1:0] IDX_FULL = 2'h3;

    // ****************************************
    // fault codes
    // ****************************************
    localparam logic [15:0] CODE_OK = 16'h0000;
    localparam logic [15:0] CODE_NO_REPLY = 16'h0001;
    localparam logic [15:0] CODE_ABORTED = 16'h0002;
    localparam logic [15:0] CODE_STATION = 16'h0003;
    localparam logic [15:0] CODE_SUM = 16'h0004;
    localparam logic [15:0] CODE_PARAM = 16'h0005;
    localparam logic [15:0] CODE_PORT = 16'h0006;
    localparam logic [15:0] CODE_RANGE = 16'h0007;
    localparam logic [15:0] CODE_SEND_TMO = 16'h0008;
    localparam logic [15:0] CODE_BAD_DATA = 16'h0009;
    // inverter error value n up to NAK_VAL_MAX maps to NAK_BASE + n
    localparam logic [15:0] CODE_NAK_BASE = 16'h0100;
    localparam logic [15:0] INSTR_OPERAND = 16'h1a32;
    localparam logic [15:0] INSTR_PORT = 16'h1a6a;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SEND = 2'b01,
        ST_WAIT = 2'b10,
        ST_RECV = 2'b11
    } txn_state_t;

endpackage

//--- inv_rx_buffer.sv
// small valid/ready buffer between the receiver and the frame checker
`timescale 1ns/1ns
module inv_rx_buffer #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 2
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // fill side
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    // drain side
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    initial begin
        if (DEPTH < 2 || WIDTH < 1) begin
            $error("inv_rx_buffer: DEPTH must be at least 2");
        end
    end

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
    logic [CW-1:0] cnt_ff, nxt_cnt;
    logic rdy_ff, nxt_rdy;
    logic wr, rd;

    assign wr = in_valid_i && rdy_ff;
    assign rd = out_ready_i && (cnt_ff != '0);
    assign in_ready_o = rdy_ff;
    assign out_valid_o = (cnt_ff != '0);
    assign out_data_o = mem_ff[rd_ff];

    // ****************************************
    // storage
    // ****************************************
    for (genvar e = 0; e < DEPTH; e++) begin : g_ent
        logic [WIDTH-1:0] nxt_mem;
        always_comb begin
            nxt_mem = mem_ff[e];
            if (wr && wr_ff == PW'(e)) begin
                nxt_mem = in_data_i;
            end
        end
        always_ff @(posedge clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                mem_ff[e] <= '0;
            end else begin
                mem_ff[e] <= nxt_mem;
            end
        end
    end

    // ****************************************
    // pointers
    // ****************************************
    always_comb begin
        nxt_wr = wr_ff;
        nxt_rd = rd_ff;
        nxt_cnt = cnt_ff;
        if (wr) begin
            nxt_wr = (wr_ff == PW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
        end
        if (rd) begin
            nxt_rd = (rd_ff == PW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
        end
        if (wr && !rd) begin
            nxt_cnt = cnt_ff + 1'b1;
        end else if (rd && !wr) begin
            nxt_cnt = cnt_ff - 1'b1;
        end
        // ready is registered so the port comes from a flop
        nxt_rdy = (nxt_cnt != CW'(DEPTH));
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
            rdy_ff <= 1'b1;
        end else begin
            wr_ff <= nxt_wr;
            rd_ff <= nxt_rd;
            cnt_ff <= nxt_cnt;
            rdy_ff <= nxt_rdy;
        end
    end
endmodule

//--- inv_link_timer.sv
// one-shot down counter shared by the send, reply and gap limits
`timescale 1ns/1ns
module inv_link_timer (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // control
    input wire logic load_i,
    input wire logic stop_i,
    input wire logic [31:0] limit_i,
    // expiry pulse, limit_i cycles after the load edge
    output logic expire_o
);
    logic [31:0] cnt_ff, nxt_cnt;
    logic armed_ff, nxt_armed;
    logic exp_ff, nxt_exp;

    assign expire_o = exp_ff;

    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_armed = armed_ff;
        nxt_exp = 1'b0;
        if (load_i) begin
            nxt_cnt = limit_i - 32'h0000_0001;
            nxt_armed = 1'b1;
        end else if (stop_i) begin
            nxt_armed = 1'b0;
        end else if (armed_ff) begin
            if (cnt_ff == '0) begin
                nxt_exp = 1'b1;
                nxt_armed = 1'b0;
            end else begin
                nxt_cnt = cnt_ff - 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_ff <= '0;
            armed_ff <= 1'b0;
            exp_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            armed_ff <= nxt_armed;
            exp_ff <= nxt_exp;
        end
    end
endmodule

//--- inv_partner_model.sv
// inverter reply model for the link error reporter bench
`timescale 1ns/1ns
module inv_partner_model #(
    parameter int RETRY_MAX = 8
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // reply order from the bench
    input wire logic go_i,
    input wire logic [7:0] station_i,
    input wire logic [7:0] kind_i,
    input wire logic [7:0] value_i,
    input wire logic [3:0] nbytes_i,
    input wire logic cut_i,
    input wire logic bad_sum_i,
    input wire logic [3:0] gap_i,
    // reply stream
    input wire logic rx_ready_i,
    output logic rx_valid_o,
    output logic [7:0] rx_data_o,
    output logic rx_last_o
);
    logic [7:0] frm [0:15];
    int naks;

    task automatic send();
        logic [7:0] sum;
        int len;
        sum = 8'h00;
        for (int i = 0; i < nbytes_i - 1; i++) begin
            frm[i] = (i == 0) ? station_i : (i == 1) ? kind_i : (i == 2) ? value_i : 8'h30;
            sum += frm[i];
        end
        frm[nbytes_i - 1] = bad_sum_i ? sum + 8'h01 : sum;
        // error values 2..5 report faults of the controller's frame
        naks = (kind_i == 8'h15) ? naks + 1 : 0;
        // alarm stop: silent once errors run past the retry count
        len = (naks > RETRY_MAX) ? 0 : cut_i ? nbytes_i - 1 : nbytes_i;
        for (int i = 0; i < len; i++) begin
            repeat (gap_i) @(posedge clk_i);
            rx_valid_o <= 1'b1;
            rx_data_o <= frm[i];
            rx_last_o <= (i == nbytes_i - 1);
            @(posedge clk_i);
            while (rx_ready_i !== 1'b1) @(posedge clk_i);
            if (gap_i != 4'h0 || i == len - 1) begin
                rx_valid_o <= 1'b0;
                rx_last_o <= 1'b0;
                // a released line shows the inverse, never a stale byte
                rx_data_o <= ~frm[i];
            end
        end
    endtask

    initial begin
        rx_valid_o = 1'b0;
        rx_data_o = 8'h5a;
        rx_last_o = 1'b0;
        naks = 0;
        forever begin
            @(posedge clk_i);
            if (go_i === 1'b1 && rst_b_i === 1'b1) send();
        end
    end
endmodule

//--- test_inverter_link_error_reporter.sv
// self-checking bench for the inverter link error reporter
`timescale 1ns/1ns
`define CHK(a, b, m) begin check_count++; if ((a) !== (b)) begin errors++; $display("CHECK FAILED %0t %s", $time, m); end end
module test_inverter_link_error_reporter;
    logic clk_i, rst_b_i, start_i, param_ok_i, port_claimed_i, tx_done_i;
    logic rx_valid_i, rx_last_i, rx_ready_o, busy_o, done_o, err_flag_o;
    logic [7:0] station_i, rx_data_i, p_st, p_kind, p_val, st_r;
    logic [15:0] err_code_o, instruction_fault_register_o, last_ins;
    logic p_go, p_cut, p_bad;
    logic [3:0] p_nb, p_gap;
    logic [15:0] code_q[$];
    logic [15:0] ins_q[$];
    int errors, check_count, dones;

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // short limits keep the timeout cases quick
    inv_link_error_reporter #(.SEND_CYC(20), .REPLY_CYC(40), .GAP_CYC(20)) dut (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .start_i(start_i), .station_i(station_i),
        .param_ok_i(param_ok_i), .port_claimed_i(port_claimed_i), .tx_done_i(tx_done_i),
        .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .rx_last_i(rx_last_i),
        .rx_ready_o(rx_ready_o), .busy_o(busy_o), .done_o(done_o), .err_flag_o(err_flag_o),
        .err_code_o(err_code_o), .instruction_fault_register_o(instruction_fault_register_o));

    inv_partner_model partner (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .go_i(p_go), .station_i(p_st), .kind_i(p_kind),
        .value_i(p_val), .nbytes_i(p_nb), .cut_i(p_cut), .bad_sum_i(p_bad), .gap_i(p_gap),
        .rx_ready_i(rx_ready_o), .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i),
        .rx_last_o(rx_last_i));

    // ****************************************
    // result watcher
    // ****************************************
    always @(posedge clk_i) begin
        if (done_o === 1'b1) begin
            dones++;
            if (code_q.size() == 0) begin
                `CHK(1'b0, 1'b1, "unexpected done")
            end else begin
                `CHK(err_code_o, code_q[0], "code")
                `CHK(err_flag_o, code_q[0] != 16'h0000, "flag")
                `CHK(instruction_fault_register_o, ins_q[0], "instr fault")
                void'(code_q.pop_front());
                void'(ins_q.pop_front());
            end
        end
    end

    task automatic wrap_up();
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ****************************************
    // transaction driver
    // ****************************************
    // fl: {reply before send ends, port claimed, parameter ok}; flt: {bad sum, cut}
    task automatic txn(input logic [7:0] st, input logic [2:0] fl, input int txd,
                       input logic [7:0] rs, input logic [7:0] kd, input logic [7:0] vl,
                       input logic [3:0] nb, input logic [1:0] flt, input logic [15:0] code);
        int n0;
        n0 = dones;
        if (code == 16'h0005 || code == 16'h0007) last_ins = 16'h1a32;
        if (code == 16'h0006) last_ins = 16'h1a6a;
        code_q.push_back(code);
        ins_q.push_back(last_ins);
        start_i <= 1'b1;
        station_i <= st;
        param_ok_i <= fl[0];
        port_claimed_i <= fl[1];
        p_st <= rs;
        p_kind <= kd;
        p_val <= vl;
        p_nb <= nb;
        p_cut <= flt[0];
        p_bad <= flt[1];
        p_gap <= 4'($urandom_range(0, 3));
        p_go <= fl[2];
        @(posedge clk_i);
        start_i <= 1'b0;
        p_go <= 1'b0;
        if (fl[1] || st > 8'h1f || !fl[0]) begin
            // busy would show one edge after the start edge
            @(posedge clk_i);
            `CHK(busy_o, 1'b0, "busy on refused start")
        end else if (txd >= 0) begin
            repeat (txd) @(posedge clk_i);
            if (fl[2]) `CHK(rx_ready_o, 1'b0, "buffer never refused")
            tx_done_i <= 1'b1;
            p_go <= !fl[2] && nb != 4'h0;
            @(posedge clk_i);
            tx_done_i <= 1'b0;
            p_go <= 1'b0;
        end
        for (int i = 0; i < 300 && dones == n0; i++) @(posedge clk_i);
        `CHK(dones != n0, 1'b1, "no done")
    endtask

    initial begin
        {start_i, param_ok_i, port_claimed_i, tx_done_i, p_go, p_cut, p_bad} = '0;
        {station_i, p_st, p_kind, p_val, p_nb, p_gap} = '0;
        rst_b_i = 1'b0;
        last_ins = 16'h0000;
        void'($urandom(36547));
        repeat (2) @(posedge clk_i);
        rst_b_i <= 1'b1;
        @(posedge clk_i);
        `CHK({busy_o, done_o, err_flag_o, rx_ready_o}, 4'b0001, "reset outputs")
        `CHK(err_code_o, 16'h0000, "reset code")
        st_r = 8'($urandom_range(0, 31));
        txn(st_r, 3'b001, 2, st_r, 8'h06, 8'h00, 4'h3, 2'b00, 16'h0000);
        // long enough for two early bytes with the widest gap to fill the buffer
        txn(8'h05, 3'b101, 12, 8'h05, 8'h06, 8'h11, 4'h6, 2'b00, 16'h0000);
        txn(8'h28, 3'b010, 0, 8'h00, 8'h06, 8'h00, 4'h3, 2'b00, 16'h0006);
        txn(8'h01, 3'b000, 0, 8'h00, 8'h06, 8'h00, 4'h3, 2'b00, 16'h0005);
        txn(8'h20, 3'b001, 0, 8'h00, 8'h06, 8'h00, 4'h3, 2'b00, 16'h0007);
        txn(8'h1f, 3'b001, -1, 8'h1f, 8'h06, 8'h00, 4'h3, 2'b00, 16'h0008);
        txn(8'h1f, 3'b001, 3, 8'h1f, 8'h06, 8'h00, 4'h0, 2'b00, 16'h0001);
        txn(8'h02, 3'b001, 1, 8'h02, 8'h06, 8'h00, 4'h3, 2'b01, 16'h0002);
        txn(8'h02, 3'b001, 1, 8'h03, 8'h06, 8'h00, 4'h3, 2'b00, 16'h0003);
        txn(8'h02, 3'b001, 1, 8'h02, 8'h06, 8'h00, 4'h3, 2'b10, 16'h0004);
        txn(8'h02, 3'b001, 1, 8'h02, 8'h06, 8'h00, 4'h2, 2'b00, 16'h0009);
        txn(8'h02, 3'b001, 1, 8'h02, 8'h41, 8'h00, 4'h3, 2'b00, 16'h0009);
        txn(8'h02, 3'b001, 1, 8'h02, 8'h15, 8'h06, 4'h4, 2'b00, 16'h0009);
        for (int v = 0; v < 6; v++) begin
            txn(8'h07, 3'b001, 2, 8'h07, 8'h15, 8'(v), 4'h4, 2'b00, 16'h0100 + 16'(v));
        end
        txn(8'h00, 3'b001, 0, 8'h00, 8'h06, 8'h00, 4'h3, 2'b00, 16'h0000);
        wrap_up();
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        errors++;
        wrap_up();
    end
endmodule
